// [shared/olds_pkg.sv]
// Summary of operation
// - off-state open-load check runs through every off period, for either sense ratio
// - off comparator above threshold sets the channel's open_load_off_fault bit
// - fault pin returns high when off fault goes; latched bit stays until read
// - off_openload_disable set to 1 suppresses off-state open-load detection
// - on-state undercurrent drives fault pin low, sets open_load_on_fault, channel stays on
// - high ratio: fault pin goes high once on-state cause is gone, low ratio: at the next fault-free check; latched bit remains set
// - high ratio: read when off clears on fault; when on, only if cause gone
// - low ratio on-state check is periodic and needs fast slew rate
// - internal PWM low ratio: check at first turn-off 150 ms after last; full duty too
// - direct input low ratio: check at every turn-off, none at full duty
// - low ratio: on fault clears only on read after a fault-free check event
// - sense_select chooses channel 0, channel 1 or temperature on the sense output
// - during an overcurrent window sensing is off and sense_valid_strobe is high
// - hold_mode_select resets to 0; 0 synchronous, 1 track-and-hold
// - synchronous: strobe low from settled until switch-off; no current after turn-off
// - track-and-hold: sample at switch-off, keep reporting it, strobe high
// - changing the sensed channel discards the held value; an off channel gives none
// - sense_ratio_select picks high or low ratio; low ratio lowers overcurrent thresholds
// - offset_sign_select (bit 8 of retry register) sets offset polarity; 1 positive
`default_nettype none
package olds_pkg;
    // register byte offsets
    localparam logic [7:0] GEN_CFG_OFS   = 8'h00;
    localparam logic [7:0] OC_CFG_OFS    = 8'h04;
    localparam logic [7:0] CH0_CFG_OFS   = 8'h08;
    localparam logic [7:0] CH1_CFG_OFS   = 8'h0C;
    localparam logic [7:0] CH0_RETRY_OFS = 8'h10;
    localparam logic [7:0] CH1_RETRY_OFS = 8'h14;
    localparam logic [7:0] FAULT_OFS     = 8'h18;
    // field positions
    localparam int SENSE_SEL_LSB    = 0;
    localparam int HOLD_MODE_BIT    = 2;
    localparam int RATIO_SEL_BIT    = 0;
    localparam int OFF_OL_DIS_BIT   = 0;
    localparam int ON_OL_DIS_BIT    = 1;
    localparam int DIR_IN_DIS_BIT   = 5;
    localparam int OFFSET_SIGN_BIT  = 8;
    localparam int FAULT_RT_LSB     = 8;
    // reset values
    localparam logic [2:0] GEN_CFG_RST   = 3'h0;
    localparam logic       OC_CFG_RST    = 1'b0;
    localparam logic [2:0] CH_CFG_RST    = 3'h0;
    localparam logic       RETRY_RST     = 1'b0;
    // sense source codes
    localparam logic [1:0] SENSE_NONE = 2'h0;
    localparam logic [1:0] SENSE_CH0  = 2'h1;
    localparam logic [1:0] SENSE_CH1  = 2'h2;
    localparam logic [1:0] SENSE_TEMP = 2'h3;
    // timing
    localparam int CLK_MHZ            = 200;
    localparam int LOW_CHECK_PERIOD_MS = 150;
    localparam int LOW_CHECK_CYCLES   = LOW_CHECK_PERIOD_MS * 1000 * CLK_MHZ;

    // per-channel analog comparator flags
    typedef struct packed {
        logic off_above;   // output above off-state open-load threshold
        logic on_below;    // load current below on-state threshold
        logic settled;     // sense output settled after turn-on
    } olds_cmp_t;

    // per-channel configuration bits
    typedef struct packed {
        logic direct_input_disable;
        logic on_openload_disable;
        logic off_openload_disable;
    } olds_chcfg_t;
endpackage
`default_nettype wire

// [src/olds_ctrl.sv]
// Chosen here: the AHB-Lite register port and the address map.
`default_nettype none
module olds_ctrl #(
    parameter int unsigned P_CHECK_CYCLES = olds_pkg::LOW_CHECK_CYCLES
) (
    input  wire logic                    i_ref_clk,
    input  wire logic                    i_resetn,
    input  wire logic                    i_ce,
    // ahb-lite slave
    input  wire logic                    i_hsel,
    input  wire logic [31:0]             i_haddr,
    input  wire logic [1:0]              i_htrans,
    input  wire logic                    i_hwrite,
    input  wire logic [2:0]              i_hsize,
    input  wire logic [31:0]             i_hwdata,
    input  wire logic                    i_hready,
    output logic                         o_hreadyout,
    output logic                         o_hresp,
    output logic [31:0]                  o_hrdata,
    // channel control from the switch logic
    input  wire logic [1:0]              i_chan_on,
    input  wire logic [1:0]              i_direct_mode,
    input  wire logic [1:0]              i_fast_slew,
    input  wire logic [1:0]              i_oc_window,
    input  wire olds_pkg::olds_cmp_t [1:0] i_cmp,
    // outputs
    output logic                         o_fault_status_pin_n,
    output logic                         o_sense_valid_strobe,
    output logic [1:0]                   o_sense_source,
    output logic                         o_sense_enable,
    output logic                         o_sense_hold,
    output logic                         o_sample_pulse,
    output logic                         o_low_ratio,
    output logic [1:0]                   o_offset_positive
);
    import olds_pkg::*;

    localparam int TW = 26;

    // refuse periods the timer cannot hold
    if (P_CHECK_CYCLES < 2 || P_CHECK_CYCLES > (1 << TW) - 1) begin : g_bad_period
        $error("P_CHECK_CYCLES out of range");
    end

    // configuration registers
    logic [1:0]  sense_select_r;
    logic        hold_mode_select_r;
    logic        sense_ratio_select_r;
    olds_chcfg_t chcfg_r [2];
    logic [1:0]  offset_sign_select_r;

    // bus phase capture
    logic        wr_pend_r;
    logic        rd_fault_r;
    logic [7:0]  wr_addr_r;
    logic        addr_ok;

    // synchronisers for comparator pins
    logic [5:0]  s1_r, s2_r, s3_r, filt_r;
    olds_cmp_t   cmp_f [2];

    // fault state
    logic [1:0]  off_fault_r;
    logic [1:0]  on_fault_r;
    logic [1:0]  low_rt_r;
    logic [1:0]  ok_seen_r;
    logic [1:0]  off_rt, high_rt, on_rt;
    logic [1:0]  chan_on_q_r;
    logic [1:0]  toff_edge;
    logic [1:0]  check_evt;
    logic [1:0]  stayed_on_r;
    logic [TW-1:0] timer_r [2];
    logic [1:0]  expired;
    logic        fault_rd;

    // sense state
    logic        held_valid_r;
    logic [1:0]  sel_q_r;
    logic        sel_is_ch;
    logic        sel_idx;

    // non-idle, word-sized, aligned transfer; narrower accesses are ignored
    function automatic logic is_word_access(input logic [1:0] tr, input logic [2:0] sz,
                                            input logic [1:0] lo);
        return tr[1] && sz == 3'h2 && lo == 2'h0;
    endfunction

    // slave always ready, always OKAY
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;
    assign addr_ok     = i_hsel && i_hready &&
                         is_word_access(i_htrans, i_hsize, i_haddr[1:0]);

    // address phase capture; fault read clears one cycle later
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_pend_r  <= 1'b0;
            rd_fault_r <= 1'b0;
            wr_addr_r  <= 8'h00;
        end else if (i_ce) begin
            wr_pend_r  <= addr_ok && i_hwrite;
            rd_fault_r <= addr_ok && !i_hwrite && i_haddr[31:0] == {24'h0, FAULT_OFS};
            wr_addr_r  <= i_haddr[7:0];
        end
    end
    // the clear lands in the data phase, after hrdata has been captured
    assign fault_rd = rd_fault_r && i_ce;

    // read data registered at the address phase
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_hrdata <= 32'h0;
        end else if (i_ce) begin
            o_hrdata <= 32'h0;
            if (addr_ok && !i_hwrite && i_haddr[31:8] == 24'h0) begin
                unique case (i_haddr[7:0])
                    GEN_CFG_OFS:   o_hrdata <= {29'h0, hold_mode_select_r, sense_select_r};
                    OC_CFG_OFS:    o_hrdata <= {31'h0, sense_ratio_select_r};
                    CH0_CFG_OFS:   o_hrdata <= {26'h0, chcfg_r[0].direct_input_disable, 3'h0,
                                                chcfg_r[0].on_openload_disable,
                                                chcfg_r[0].off_openload_disable};
                    CH1_CFG_OFS:   o_hrdata <= {26'h0, chcfg_r[1].direct_input_disable, 3'h0,
                                                chcfg_r[1].on_openload_disable,
                                                chcfg_r[1].off_openload_disable};
                    CH0_RETRY_OFS: o_hrdata <= {23'h0, offset_sign_select_r[0], 8'h0};
                    CH1_RETRY_OFS: o_hrdata <= {23'h0, offset_sign_select_r[1], 8'h0};
                    FAULT_OFS:     o_hrdata <= {20'h0, on_rt[1], off_rt[1], on_rt[0],
                                                off_rt[0], 4'h0, on_fault_r[1], off_fault_r[1],
                                                on_fault_r[0], off_fault_r[0]};
                    default:       o_hrdata <= 32'h0;
                endcase
            end
        end
    end

    // register writes in the data phase
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sense_select_r       <= GEN_CFG_RST[1:0];
            hold_mode_select_r   <= GEN_CFG_RST[HOLD_MODE_BIT];
            sense_ratio_select_r <= OC_CFG_RST;
            chcfg_r[0]           <= CH_CFG_RST;
            chcfg_r[1]           <= CH_CFG_RST;
            offset_sign_select_r <= {2{RETRY_RST}};
        end else if (i_ce && wr_pend_r) begin
            unique case (wr_addr_r)
                GEN_CFG_OFS: begin
                    sense_select_r     <= i_hwdata[SENSE_SEL_LSB +: 2];
                    hold_mode_select_r <= i_hwdata[HOLD_MODE_BIT];
                end
                OC_CFG_OFS:    sense_ratio_select_r <= i_hwdata[RATIO_SEL_BIT];
                CH0_CFG_OFS:   chcfg_r[0] <= {i_hwdata[DIR_IN_DIS_BIT],
                                              i_hwdata[ON_OL_DIS_BIT], i_hwdata[OFF_OL_DIS_BIT]};
                CH1_CFG_OFS:   chcfg_r[1] <= {i_hwdata[DIR_IN_DIS_BIT],
                                              i_hwdata[ON_OL_DIS_BIT], i_hwdata[OFF_OL_DIS_BIT]};
                CH0_RETRY_OFS: offset_sign_select_r[0] <= i_hwdata[OFFSET_SIGN_BIT];
                CH1_RETRY_OFS: offset_sign_select_r[1] <= i_hwdata[OFFSET_SIGN_BIT];
                default: ;
            endcase
        end
    end

    // three-stage pin sync; change taken when stages two and three agree
    // stage one feeds stage two only, as its value may still be settling
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s1_r   <= 6'h0;
            s2_r   <= 6'h0;
            s3_r   <= 6'h0;
            filt_r <= 6'h0;
        end else if (i_ce) begin
            s1_r   <= {i_cmp[1], i_cmp[0]};
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            filt_r <= (s2_r & ~(s2_r ^ s3_r)) | (filt_r & (s2_r ^ s3_r));
        end
    end
    assign cmp_f[0] = filt_r[2:0];
    assign cmp_f[1] = filt_r[5:3];

    // real-time fault terms and check events per channel
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            toff_edge[c] = chan_on_q_r[c] && !i_chan_on[c];
            // timer saturates, so an idle channel cannot wrap into an early check
            expired[c]   = timer_r[c] >= TW'(P_CHECK_CYCLES - 1);
            // off check in every off period, either ratio
            off_rt[c]    = !i_chan_on[c] && !chcfg_r[c].off_openload_disable
                           && cmp_f[c].off_above;
            high_rt[c]   = !sense_ratio_select_r && i_chan_on[c] &&
                           !chcfg_r[c].on_openload_disable && cmp_f[c].on_below;
            on_rt[c]     = high_rt[c] || (sense_ratio_select_r && low_rt_r[c]);
            // low ratio: periodic check, fast slew only
            if (!sense_ratio_select_r || !i_fast_slew[c] ||
                chcfg_r[c].on_openload_disable) begin
                check_evt[c] = 1'b0;
            end else if (i_direct_mode[c] && !chcfg_r[c].direct_input_disable) begin
                check_evt[c] = toff_edge[c];
            end else begin
                // full duty: no turn-off since the last check, on for two cycles
                check_evt[c] = expired[c] && (toff_edge[c] ||
                               (stayed_on_r[c] && chan_on_q_r[c] && i_chan_on[c]));
            end
        end
    end

    // check timer and full-duty tracking
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            chan_on_q_r <= 2'h0;
            stayed_on_r <= 2'h0;
            timer_r[0]  <= '0;
            timer_r[1]  <= '0;
        end else if (i_ce) begin
            chan_on_q_r <= i_chan_on;
            for (int c = 0; c < 2; c++) begin
                if (check_evt[c]) begin
                    timer_r[c]     <= '0;
                    stayed_on_r[c] <= 1'b1; // a new period starts unbroken
                end else begin
                    if (!expired[c])
                        timer_r[c] <= timer_r[c] + TW'(1);
                    // only a real turn-off breaks it; trade-off: after a long off
                    // time the first check may come two cycles after turn-on
                    if (toff_edge[c])
                        stayed_on_r[c] <= 1'b0; // a turn-off breaks full duty
                end
            end
        end
    end

    // latched fault bits; a set in the clearing cycle wins
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            off_fault_r <= 2'h0;
            on_fault_r  <= 2'h0;
            low_rt_r    <= 2'h0;
            ok_seen_r   <= 2'h0;
        end else if (i_ce) begin
            for (int c = 0; c < 2; c++) begin
                if (off_rt[c])
                    off_fault_r[c] <= 1'b1;
                else if (fault_rd)
                    off_fault_r[c] <= 1'b0;
                // low ratio: the event result stands until the next event
                if (check_evt[c]) begin
                    low_rt_r[c]  <= cmp_f[c].on_below;
                    ok_seen_r[c] <= !cmp_f[c].on_below;
                end else if (fault_rd || !sense_ratio_select_r) begin
                    ok_seen_r[c] <= 1'b0;
                end
                if (!sense_ratio_select_r)
                    low_rt_r[c] <= 1'b0;
                if (high_rt[c] || (check_evt[c] && cmp_f[c].on_below))
                    on_fault_r[c] <= 1'b1;
                else if (fault_rd && !sense_ratio_select_r &&
                         (!i_chan_on[c] || !cmp_f[c].on_below))
                    on_fault_r[c] <= 1'b0;
                else if (fault_rd && sense_ratio_select_r && ok_seen_r[c])
                    on_fault_r[c] <= 1'b0;
            end
        end
    end

    // fault pin follows real-time causes only
    assign o_fault_status_pin_n = ~|(off_rt | on_rt);

    // sense routing
    assign sel_is_ch     = sense_select_r == SENSE_CH0 || sense_select_r == SENSE_CH1;
    assign sel_idx       = sense_select_r == SENSE_CH1;
    assign o_sense_source = sense_select_r;
    assign o_low_ratio   = sense_ratio_select_r;
    assign o_offset_positive = offset_sign_select_r;

    // track-and-hold capture; channel change drops the held value
    // the sample pulse marks the edge at which the held value was taken
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            held_valid_r   <= 1'b0;
            sel_q_r        <= SENSE_NONE;
            o_sample_pulse <= 1'b0;
        end else if (i_ce) begin
            sel_q_r        <= sense_select_r;
            o_sample_pulse <= 1'b0;
            if (sense_select_r != sel_q_r || !hold_mode_select_r || !sel_is_ch) begin
                held_valid_r <= 1'b0;
            end else if (toff_edge[sel_idx] && !i_oc_window[sel_idx]) begin
                held_valid_r   <= 1'b1;
                o_sample_pulse <= 1'b1;
            end else if (i_chan_on[sel_idx]) begin
                held_valid_r <= 1'b0; // tracking again
            end
        end
    end

    // sense enable and valid strobe
    always_comb begin
        o_sense_enable       = 1'b0;
        o_sense_hold         = 1'b0;
        o_sense_valid_strobe = 1'b1;
        if (sense_select_r == SENSE_TEMP) begin
            o_sense_enable = 1'b1;
        end else if (sel_is_ch && !i_oc_window[sel_idx]) begin
            if (i_chan_on[sel_idx] && cmp_f[sel_idx].settled) begin
                o_sense_enable       = 1'b1;
                o_sense_valid_strobe = 1'b0;
            end else if (hold_mode_select_r && held_valid_r && !i_chan_on[sel_idx]) begin
                o_sense_enable = 1'b1;
                o_sense_hold   = 1'b1;
            end
        end
    end

    // checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);

    // fault latching, read clears and the fault pin
    a_off_fault_set: assert property (i_ce && off_rt[0] |=> off_fault_r[0])
        else $error("off fault not latched");
    a_off_fault_hold: assert property (i_ce && off_fault_r[0] && !fault_rd |=> off_fault_r[0])
        else $error("off fault dropped without read");
    a_off_disable: assert property (chcfg_r[0].off_openload_disable |-> !off_rt[0])
        else $error("off check not suppressed");
    a_pin_follows: assert property (!i_chan_on[0] && !chcfg_r[0].off_openload_disable &&
                                    cmp_f[0].off_above |-> !o_fault_status_pin_n)
        else $error("fault pin not low for off-state open load");
    a_on_fault_set: assert property (i_ce && high_rt[0] |=> on_fault_r[0])
        else $error("on fault not latched");
    a_high_read_clr: assert property (i_ce && fault_rd && !sense_ratio_select_r &&
                                      !i_chan_on[0] && !high_rt[0] |=> !on_fault_r[0])
        else $error("off-state read did not clear on fault");
    a_low_needs_ok: assert property (i_ce && sense_ratio_select_r && on_fault_r[0] &&
                                     !ok_seen_r[0] && !check_evt[0] |=> on_fault_r[0])
        else $error("low ratio on fault cleared early");

    // low-ratio check scheduling
    a_low_slew: assert property (!i_fast_slew[0] |-> !check_evt[0])
        else $error("check without fast slew");
    a_direct_check: assert property (sense_ratio_select_r && i_fast_slew[0] &&
                                     i_direct_mode[0] && !chcfg_r[0].direct_input_disable &&
                                     !chcfg_r[0].on_openload_disable && toff_edge[0]
                                     |-> check_evt[0])
        else $error("direct turn-off check missed");
    a_timer_gap: assert property (check_evt[0] && i_ce &&
                                  !(i_direct_mode[0] && !chcfg_r[0].direct_input_disable)
                                  |=> !check_evt[0] [*2])
        else $error("internal check repeated too soon");

    // sense strobe and track-and-hold
    a_oc_strobe: assert property (sel_is_ch && i_oc_window[sel_idx]
                                  |-> o_sense_valid_strobe && !o_sense_enable)
        else $error("sensing during overcurrent window");
    a_sync_off: assert property (!hold_mode_select_r && sel_is_ch && !i_chan_on[sel_idx]
                                 |-> !o_sense_enable && o_sense_valid_strobe)
        else $error("sync mode reports current while off");
    a_hold_sample: assert property (i_ce && hold_mode_select_r && sel_is_ch &&
                                    sense_select_r == sel_q_r && toff_edge[sel_idx] &&
                                    !i_oc_window[sel_idx] |=> o_sample_pulse && held_valid_r)
        else $error("track-and-hold sample missed");
    a_hold_discard: assert property (i_ce && sense_select_r != sel_q_r |=> !held_valid_r)
        else $error("held value kept across channel change");


    // scenarios worth seeing in a run
    c_off_fault: cover property (off_rt[0] ##1 !off_rt[0] ##1 fault_rd);
    c_low_check: cover property (check_evt[0] && !cmp_f[0].on_below);
    c_hold: cover property (o_sample_pulse ##1 o_sense_hold);
    c_oc_window: cover property (sel_is_ch && i_oc_window[sel_idx]);
    c_full_duty: cover property (check_evt[0] && stayed_on_r[0] && !toff_edge[0]);
endmodule
`default_nettype wire

// [dv/olds_mcu_model.sv]
`default_nettype none
// controller side of the register bus; no fixed wait count is assumed
module olds_mcu_model (
    input  wire logic        i_ref_clk,
    input  wire logic        i_hready,
    input  wire logic [31:0] i_hrdata,
    output logic [31:0]      o_haddr,
    output logic [1:0]       o_htrans,
    output logic             o_hwrite,
    output logic [31:0]      o_hwdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus at time zero
    initial begin
        o_haddr = 32'h0;
        o_htrans = 2'h0;
        o_hwrite = 1'b0;
        o_hwdata = 32'h0;
    end
    // single word transfer, held until hready is seen high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        @(posedge i_ref_clk);
        o_haddr <= {24'h0, a};
        o_htrans <= 2'h2;
        o_hwrite <= w;
        do @(posedge i_ref_clk); while (i_hready !== 1'b1);
        o_htrans <= 2'h0;
        o_hwdata <= d;
        do @(posedge i_ref_clk); while (i_hready !== 1'b1);
        r = i_hrdata;
    endtask
endmodule
`default_nettype wire

// [dv/olds_ctrl_tb_top.sv]
`default_nettype none
module olds_ctrl_tb_top;
    import olds_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CHK = 50;
    logic            clk = 1'b0;
    logic            rstn_n = 1'b0;
    logic [1:0]      on = 2'h0, dm = 2'h0, fs = 2'h0, oc = 2'h0, src, ofs;
    olds_cmp_t [1:0] cmp = '0;
    logic [31:0]     haddr, hwdata, hrdata, d;
    logic [1:0]      htrans;
    logic            hwrite, hrdy, fpin, strb, en, hold, smp, lowr;
    int              fails = 0, total_checks = 0, cyc = 0, n;
    int              seed = 32'hef894c75;
    always #2.5 clk = ~clk;
    olds_ctrl #(.P_CHECK_CYCLES(CHK)) dut (
        .i_ref_clk(clk), .i_resetn(rstn_n), .i_ce(1'b1), .i_hsel(1'b1),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
        .i_hwdata(hwdata), .i_hready(hrdy), .o_hreadyout(hrdy), .o_hresp(),
        .o_hrdata(hrdata), .i_chan_on(on), .i_direct_mode(dm), .i_fast_slew(fs),
        .i_oc_window(oc), .i_cmp(cmp), .o_fault_status_pin_n(fpin),
        .o_sense_valid_strobe(strb), .o_sense_source(src), .o_sense_enable(en),
        .o_sense_hold(hold), .o_sample_pulse(smp), .o_low_ratio(lowr),
        .o_offset_positive(ofs));
    olds_mcu_model mcu (.i_ref_clk(clk), .i_hready(hrdy), .i_hrdata(hrdata),
        .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite), .o_hwdata(hwdata));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // hang guard, well above the expected run length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            tally_and_finish();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] x;
        mcu.xfer(1'b1, a, v, x);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        mcu.xfer(1'b0, a, 32'h0, x);
        chk(nm, e, x);
    endtask
    // latched bits low, live bits from bit 8; comparator filter needs 4 edges
    function automatic logic [31:0] fx(input logic [3:0] lat, input logic [3:0] rt);
        return {20'h0, rt, 4'h0, lat};
    endfunction
    task automatic w8(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rstn_n <= 1'b1;
        rdc("gen_rst", GEN_CFG_OFS, 32'h0);
        chk("pin_idle", 32'h1, fpin);
        $display("test reset done");
        // off-state open load under both sense ratios
        for (int r = 0; r < 2; r++) begin
            wr(OC_CFG_OFS, r);
            w8(1);
            chk("low_ratio", r, lowr);
            cmp[0].off_above <= 1'b1;
            w8(8);
            chk("pin_off", 32'h0, fpin);
            cmp[0].off_above <= 1'b0;
            w8(8);
            chk("pin_back", 32'h1, fpin);
            rdc("f_off", FAULT_OFS, fx(4'h1, 4'h0));
            rdc("f_clr", FAULT_OFS, 32'h0);
        end
        wr(CH0_CFG_OFS, 32'h1);
        cmp[0].off_above <= 1'b1;
        w8(8);
        chk("pin_dis", 32'h1, fpin);
        rdc("f_dis", FAULT_OFS, 32'h0);
        cmp[0].off_above <= 1'b0;
        w8(8); // filtered comparator must drop before the check is re-enabled
        wr(CH0_CFG_OFS, 32'h0);
        wr(OC_CFG_OFS, 32'h0);
        $display("test off_open done");
        // high ratio on-state open load, clear rules on and off
        on[0] <= 1'b1;
        cmp[0].on_below <= 1'b1;
        w8(8);
        chk("pin_on", 32'h0, fpin);
        rdc("f_on", FAULT_OFS, fx(4'h2, 4'h2));
        rdc("f_keep", FAULT_OFS, fx(4'h2, 4'h2));
        cmp[0].on_below <= 1'b0;
        w8(8);
        chk("pin_gone", 32'h1, fpin);
        rdc("f_lat", FAULT_OFS, fx(4'h2, 4'h0));
        rdc("f_gone", FAULT_OFS, 32'h0);
        cmp[0].on_below <= 1'b1;
        w8(8);
        on[0] <= 1'b0;
        w8(3);
        rdc("f_offrd", FAULT_OFS, fx(4'h2, 4'h0));
        rdc("f_offclr", FAULT_OFS, 32'h0);
        $display("test on_high done");
        // low ratio periodic checks: slow slew, direct input, full duty
        wr(OC_CFG_OFS, 32'h1);
        dm[0] <= 1'b1;
        for (int s = 0; s < 2; s++) begin
            fs[0] <= s[0];
            on[0] <= 1'b1;
            w8(5);
            on[0] <= 1'b0;
            w8(3);
            rdc("f_low", FAULT_OFS, fx({2'h0, s[0], 1'b0}, {2'h0, s[0], 1'b0}));
        end
        cmp[0].on_below <= 1'b0;
        w8(6);
        rdc("f_noevt", FAULT_OFS, fx(4'h2, 4'h2));
        on[0] <= 1'b1;
        w8(3);
        on[0] <= 1'b0;
        w8(3);
        rdc("f_clean", FAULT_OFS, fx(4'h2, 4'h0));
        rdc("f_lowclr", FAULT_OFS, 32'h0);
        cmp[0].on_below <= 1'b1;
        on[0] <= 1'b1;
        w8(CHK + 20);
        rdc("f_dirfull", FAULT_OFS, 32'h0);
        wr(CH0_CFG_OFS, 32'h20);
        w8(CHK + 20);
        rdc("f_pwmfull", FAULT_OFS, fx(4'h2, 4'h2));
        on[0] <= 1'b0;
        cmp[0].on_below <= 1'b0;
        wr(CH0_CFG_OFS, 32'h0);
        wr(OC_CFG_OFS, 32'h0);
        rdc("f_end", FAULT_OFS, fx(4'h2, 4'h0));
        $display("test on_low done");
        // source select and offset polarity with random upper bits
        for (int s = 0; s < 4; s++) begin
            d = $random(seed);
            wr(GEN_CFG_OFS, {d[31:3], 1'b0, s[1:0]});
            wr(CH1_RETRY_OFS, d);
            w8(1);
            chk("src", s, src);
            chk("ofs", {d[8], 1'b0}, ofs);
        end
        $display("test select done");
        // synchronous sensing, then overcurrent window
        wr(GEN_CFG_OFS, {29'h0, 1'b0, SENSE_CH0});
        cmp[0].settled <= 1'b1;
        on[0] <= 1'b1;
        w8(8);
        chk("strb_sync", 32'h0, strb);
        oc[0] <= 1'b1;
        w8(1);
        chk("strb_oc", 32'h2, {strb, en});
        oc[0] <= 1'b0;
        on[0] <= 1'b0;
        w8(2);
        chk("strb_offs", 32'h2, {strb, en});
        $display("test sync done");
        // track and hold at switch-off, lost on reselect of an off channel
        wr(GEN_CFG_OFS, {29'h0, 1'b1, SENSE_CH0});
        on[0] <= 1'b1;
        w8(8);
        on[0] <= 1'b0;
        n = 0;
        repeat (4) begin
            w8(1);
            n += smp;
        end
        chk("pulse", 32'h1, n);
        chk("th_hold", 32'h3, {strb, hold});
        wr(GEN_CFG_OFS, {29'h0, 1'b1, SENSE_CH1});
        w8(2);
        chk("th_lost", 32'h0, hold);
        $display("test hold done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
